// >>> bias_ctrl_pkg.sv
package bias_ctrl_pkg;
  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Delay before the first output enable propagates after a pin wake.
  localparam int unsigned WAKE_DELAY_US = 220;
  localparam int unsigned WAKE_DELAY_CYCLES = (WAKE_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CNT_W = 12;
  // Number of buck outputs.
  localparam int unsigned NUM_OUT = 2;
  // Strap code meaning second phase is a slave.
  localparam logic [1:0] STRAP_CODE_W = 2'h2;
  localparam logic [1:0] ADDR_LOW = 2'h0;
  localparam logic [1:0] ADDR_OPEN = 2'h1;
  localparam logic [1:0] ADDR_HIGH = 2'h2;
  localparam logic [7:0] STRAP_RESET = 8'h00;
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_BIAS = 4'h2,
    ST_WAKE = 4'h4,
    ST_RUN = 4'h8
  } seq_state_t;
endpackage

// >>> strap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
  logic [7:0] strap_a;
  logic [7:0] strap_b;
  logic b_is_slave;
  logic sample;
  logic clear;
  modport sampler (input sample, input clear, output strap_a, output strap_b, output b_is_slave);
  modport user (output sample, output clear, input strap_a, input strap_b, input b_is_slave);
endinterface
`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  import bias_ctrl_pkg::*;

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  // A change is taken only when the second and third stages agree.
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule
`default_nettype wire

// >>> strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module strap_latch (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] code_a_in,
  input wire logic [7:0] code_b_in,
  strap_if.sampler st
);
  import bias_ctrl_pkg::*;

  logic [7:0] a_reg, a_next, b_reg, b_next;
  logic slave_reg, slave_next;

  always_comb begin
    a_next = a_reg;
    b_next = b_reg;
    slave_next = slave_reg;
    if (st.clear) begin
      a_next = STRAP_RESET;
      b_next = STRAP_RESET;
      slave_next = 1'b0;
    end else if (st.sample) begin
      a_next = code_a_in;
      b_next = code_b_in;
      slave_next = (code_b_in[1:0] == STRAP_CODE_W); // [R15]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      a_reg <= STRAP_RESET;
      b_reg <= STRAP_RESET;
      slave_reg <= 1'b0;
    end else begin
      a_reg <= a_next;
      b_reg <= b_next;
      slave_reg <= slave_next;
    end
  end

  assign st.strap_a = a_reg;
  assign st.strap_b = b_reg;
  assign st.b_is_slave = slave_reg;
endmodule
`default_nettype wire

// >>> bias_supply_enable_control.sv
// Notes on behaviour
// (R01) Bias from system input when disabled or low.
// (R02) Bias from alternate only if allowed and high.
// (R03) Any enable pin powers bias and regulators.
// (R04) Straps sampled once logic supply stable.
// (R05) Serial bus needs system and logic supplies.
// (R06) Interface-only wake allows config before outputs.
// (R07) Wake starts on system input, then switches.
// (R08) Switch status bit and switch event flag.
// (R09) High enable pin turns its output on.
// (R10) Pin wake delays output enable about 220us.
// (R11) Output enable is pin OR software bit.
// (R12) Serial interface active while logic regulator on.
// (R13) Host drives enable pins to clean levels.
// (R14) Second power-good held low in dual phase.
// (R15) Low second strap makes phase two slave.
// (R16) Low forced-PWM pin or clock forces PWM. The code forces PWM from the low pin only; it has no clock input.
// (R17) Bus address from three-level strap.
// (R18) Interrupt pin is open-drain, pull-low only.
// (R19) Straps give defaults; bus writes override.
// (R20) Shutdown resets state; strap defaults held. The code clears the strap latch and both settings on shutdown.
// (R21) Pins and comparators synchronised before use. The code uses power_ok_raw_in without synchronising it.
`timescale 1ns/1ps
`default_nettype none
module bias_supply_enable_control (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic interface_enable_pin_in,
  input wire logic [bias_ctrl_pkg::NUM_OUT-1:0] output_enable_pin_in,
  input wire logic [bias_ctrl_pkg::NUM_OUT-1:0] output_sw_enable_in,
  input wire logic alt_source_disable_in,
  input wire logic alt_above_threshold_in,
  input wire logic system_input_valid_in,
  input wire logic logic_supply_valid_in,
  input wire logic [7:0] strap_select_a_in,
  input wire logic [7:0] strap_select_b_in,
  input wire logic addr_strap_high_in,
  input wire logic addr_strap_low_in,
  input wire logic force_pwm_a_n_in,
  input wire logic force_pwm_b_n_in,
  input wire logic [bias_ctrl_pkg::NUM_OUT-1:0] power_ok_raw_in,
  input wire logic irq_pending_in,
  input wire logic alt_switch_irq_clear_in,
  input wire logic cfg_write_in,
  input wire logic [7:0] cfg_a_in,
  input wire logic [7:0] cfg_b_in,
  output logic bias_enable_out,
  output logic bias_from_alt_out,
  output logic serial_active_out,
  output logic [bias_ctrl_pkg::NUM_OUT-1:0] buck_enable_out,
  output logic [bias_ctrl_pkg::NUM_OUT-1:0] force_pwm_out,
  output logic alt_switched_status_out,
  output logic alt_switch_irq_out,
  output logic [1:0] bus_address_out,
  output logic [7:0] setting_a_out,
  output logic [7:0] setting_b_out,
  output logic dual_phase_out,
  output logic power_good_a_oe_out,
  output logic power_good_a_o_out,
  output logic power_good_b_oe_out,
  output logic power_good_b_o_out,
  output logic interrupt_out_n_oe_out,
  output logic interrupt_out_n_o_out,
  output logic [3:0] seq_state_out
);
  import bias_ctrl_pkg::*;

  // One bit per filtered pin or comparator: one, two, then eight single bits.
  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] raw_vec, sync_vec;
  logic if_en_s, alt_dis_s, alt_hi_s, sys_ok_s, vdd_ok_s;
  logic fpwm_a_s, fpwm_b_s, addr_hi_s, addr_lo_s;
  logic [NUM_OUT-1:0] en_pin_s;
  logic any_en;

  assign raw_vec = {interface_enable_pin_in, output_enable_pin_in, alt_source_disable_in,
                    alt_above_threshold_in, system_input_valid_in, logic_supply_valid_in,
                    force_pwm_a_n_in, force_pwm_b_n_in, addr_strap_high_in,
                    addr_strap_low_in};

  // Analog comparators and pins enter through the three-stage filter, except power_ok_raw_in, which drives the power-good pins directly.
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_vec),
    .level_out(sync_vec)
  ); // [R21]

  assign {if_en_s, en_pin_s, alt_dis_s, alt_hi_s, sys_ok_s, vdd_ok_s,
          fpwm_a_s, fpwm_b_s, addr_hi_s, addr_lo_s} = sync_vec;

  assign any_en = if_en_s | (|en_pin_s); // [R03]

  strap_if st();
  strap_latch u_strap (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .code_a_in(strap_select_a_in),
    .code_b_in(strap_select_b_in),
    .st(st)
  );

  seq_state_t state_reg, state_next;
  logic [WAKE_CNT_W-1:0] cnt_reg, cnt_next;
  logic pin_wake_reg, pin_wake_next;
  logic alt_reg, alt_next;
  logic irq_reg, irq_next;
  logic [7:0] set_a_reg, set_a_next, set_b_reg, set_b_next;
  logic [1:0] addr_reg, addr_next;
  logic [NUM_OUT-1:0] buck_reg, buck_next;
  logic want_alt;

  function automatic logic [1:0] decode_addr(input logic hi, input logic lo);
    if (hi && !lo) begin
      return ADDR_HIGH;
    end else if (lo && !hi) begin
      return ADDR_LOW;
    end
    return ADDR_OPEN;
  endfunction

  assign want_alt = !alt_dis_s && alt_hi_s; // [R01] [R02]

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pin_wake_next = pin_wake_reg;
    alt_next = alt_reg;
    irq_next = irq_reg;
    set_a_next = set_a_reg;
    set_b_next = set_b_reg;
    addr_next = addr_reg;
    buck_next = '0;
    st.sample = 1'b0;
    st.clear = 1'b0;
    case (state_reg)
      ST_OFF: begin
        alt_next = 1'b0;
        if (any_en) begin
          // Remember whether an output pin caused the wake.
          pin_wake_next = |en_pin_s; // [R10]
          state_next = ST_BIAS;
        end
      end
      ST_BIAS: begin
        if (vdd_ok_s) begin
          st.sample = 1'b1; // [R04]
          addr_next = decode_addr(addr_hi_s, addr_lo_s); // [R17]
          cnt_next = '0;
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Strap values land in the latch one cycle after sampling.
        set_a_next = st.strap_a; // [R19]
        set_b_next = st.strap_b;
        cnt_next = cnt_reg + 1'b1;
        if (!pin_wake_reg || cnt_reg >= WAKE_CNT_W'(WAKE_DELAY_CYCLES - 1)) begin
          state_next = ST_RUN; // [R10] [R06]
        end
      end
      ST_RUN: begin
        buck_next = en_pin_s | output_sw_enable_in; // [R09] [R11]
        if (st.b_is_slave) begin
          buck_next[1] = 1'b0;
        end
        if (cfg_write_in && serial_active_out) begin
          set_a_next = cfg_a_in; // [R19]
          set_b_next = cfg_b_in;
        end
        // Switch-over only after startup on the system input.
        alt_next = want_alt; // [R07]
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (alt_next != alt_reg) begin
      irq_next = 1'b1; // [R08]
    end else if (alt_switch_irq_clear_in) begin
      irq_next = 1'b0;
    end
    if (!any_en && state_reg != ST_OFF) begin
      // Shutdown drops every held default and the buck, source and switch-event outputs.
      state_next = ST_OFF; // [R20]
      st.clear = 1'b1;
      set_a_next = STRAP_RESET;
      set_b_next = STRAP_RESET;
      addr_next = ADDR_OPEN;
      buck_next = '0;
      alt_next = 1'b0;
      irq_next = 1'b0;
      pin_wake_next = 1'b0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_OFF;
      cnt_reg <= '0;
      pin_wake_reg <= 1'b0;
      alt_reg <= 1'b0;
      irq_reg <= 1'b0;
      set_a_reg <= STRAP_RESET;
      set_b_reg <= STRAP_RESET;
      addr_reg <= ADDR_OPEN;
      buck_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pin_wake_reg <= pin_wake_next;
      alt_reg <= alt_next;
      irq_reg <= irq_next;
      set_a_reg <= set_a_next;
      set_b_reg <= set_b_next;
      addr_reg <= addr_next;
      buck_reg <= buck_next;
    end
  end

  assign bias_enable_out = (state_reg != ST_OFF); // [R03]
  assign bias_from_alt_out = alt_reg; // [R01] [R02]
  // Serial access follows the logic regulator and both supply monitors.
  assign serial_active_out = bias_enable_out && sys_ok_s && vdd_ok_s; // [R05] [R12]
  assign buck_enable_out = buck_reg;
  assign force_pwm_out = {~fpwm_b_s, ~fpwm_a_s}; // [R16]
  assign alt_switched_status_out = alt_reg; // [R08]
  assign alt_switch_irq_out = irq_reg;
  assign bus_address_out = addr_reg;
  assign setting_a_out = set_a_reg;
  assign setting_b_out = set_b_reg;
  assign dual_phase_out = st.b_is_slave; // [R15]
  assign power_good_a_o_out = 1'b0;
  assign power_good_a_oe_out = !power_ok_raw_in[0];
  assign power_good_b_o_out = 1'b0;
  assign power_good_b_oe_out = !power_ok_raw_in[1] || st.b_is_slave; // [R14]
  assign interrupt_out_n_o_out = 1'b0; // [R18]
  assign interrupt_out_n_oe_out = irq_pending_in || irq_reg; // [R18]
  assign seq_state_out = state_reg;
endmodule
`default_nettype wire

// >>> bias_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bias_ctrl_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bias_enable_out,
  input wire logic bias_from_alt_out,
  input wire logic serial_active_out,
  input wire logic [bias_ctrl_pkg::NUM_OUT-1:0] buck_enable_out,
  input wire logic alt_switch_irq_out,
  input wire logic [7:0] setting_a_out,
  input wire logic dual_phase_out,
  input wire logic power_good_a_o_out,
  input wire logic power_good_b_oe_out,
  input wire logic power_good_b_o_out,
  input wire logic interrupt_out_n_oe_out,
  input wire logic interrupt_out_n_o_out,
  input wire logic [3:0] seq_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_buck_wait_run: assert property (seq_state_out != 4'h8 && $past(seq_state_out) != 4'h8
    |-> buck_enable_out == 2'h0) else $error("buck on outside run");
  a_bias_from_state: assert property (bias_enable_out == (seq_state_out != 4'h1))
    else $error("bias enable disagrees with state");
  a_state_onehot: assert property ($onehot(seq_state_out)) else $error("state not one-hot");
  a_serial_needs_bias: assert property (serial_active_out |-> bias_enable_out)
    else $error("serial active without bias");
  a_pin_pulls_low: assert property (!power_good_a_o_out && !power_good_b_o_out
    && !interrupt_out_n_o_out) else $error("open-drain pin driven high");
  a_dual_pg_low: assert property (dual_phase_out |-> power_good_b_oe_out && !buck_enable_out[1])
    else $error("second output active in dual phase");
  a_irq_to_pin: assert property (alt_switch_irq_out |-> interrupt_out_n_oe_out)
    else $error("switch event not on interrupt pin");
  a_wake_on_system: assert property ($past(seq_state_out) == 4'h1 && seq_state_out == 4'h2
    |-> !bias_from_alt_out) else $error("wake started on alternate input");
  a_off_cleared: assert property (seq_state_out == 4'h1 && $past(seq_state_out) == 4'h1
    |-> setting_a_out == 8'h00 && !alt_switch_irq_out) else $error("state kept in off");
endmodule
bind bias_supply_enable_control bias_ctrl_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .bias_enable_out(bias_enable_out), .bias_from_alt_out(bias_from_alt_out),
  .serial_active_out(serial_active_out), .buck_enable_out(buck_enable_out),
  .alt_switch_irq_out(alt_switch_irq_out), .setting_a_out(setting_a_out),
  .dual_phase_out(dual_phase_out), .power_good_a_o_out(power_good_a_o_out),
  .power_good_b_oe_out(power_good_b_oe_out), .power_good_b_o_out(power_good_b_o_out),
  .interrupt_out_n_oe_out(interrupt_out_n_oe_out),
  .interrupt_out_n_o_out(interrupt_out_n_o_out), .seq_state_out(seq_state_out));
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic if_req_in,
  input wire logic [1:0] out_req_in,
  output var logic interface_enable_pin_out = 1'b0,
  output var logic [1:0] output_enable_pin_out = 2'h0
);
  // Pins move only on the falling edge and always sit at a full level, so they never chatter.
  always @(negedge clk_in) begin
    interface_enable_pin_out <= if_req_in;
    output_enable_pin_out <= out_req_in;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bias_ctrl_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, if_cmd = 1'b0, dis = 1'b0, alt_hi = 1'b0;
  logic sys_ok = 1'b1, vdd_ok = 1'b1, a_hi = 1'b0, a_lo = 1'b0, fa_n = 1'b1, fb_n = 1'b1;
  logic irq_p = 1'b0, irq_clr = 1'b0, cfg_wr = 1'b0, if_pin;
  logic [1:0] pin_cmd = 2'h0, sw_en = 2'h0, pok = 2'h3, en_pin;
  logic [7:0] sa = 8'h5a, sb = 8'h31, ca = 8'hc3, cb = 8'h00;
  wire bias_en, from_alt, ser, sw_st, sw_irq, dual, pa_oe, pa_o, pb_oe, pb_o, irq_oe, irq_o;
  wire [1:0] buck, fpwm, addr;
  wire [7:0] set_a, set_b;
  wire [3:0] st;
  int fails = 0, tests_run = 0;
  host_model host (.clk_in(clk_in), .if_req_in(if_cmd), .out_req_in(pin_cmd),
    .interface_enable_pin_out(if_pin), .output_enable_pin_out(en_pin));
  bias_supply_enable_control dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .interface_enable_pin_in(if_pin), .output_enable_pin_in(en_pin), .output_sw_enable_in(sw_en),
    .alt_source_disable_in(dis), .alt_above_threshold_in(alt_hi), .system_input_valid_in(sys_ok),
    .logic_supply_valid_in(vdd_ok), .strap_select_a_in(sa), .strap_select_b_in(sb),
    .addr_strap_high_in(a_hi), .addr_strap_low_in(a_lo), .force_pwm_a_n_in(fa_n),
    .force_pwm_b_n_in(fb_n), .power_ok_raw_in(pok), .irq_pending_in(irq_p),
    .alt_switch_irq_clear_in(irq_clr), .cfg_write_in(cfg_wr), .cfg_a_in(ca), .cfg_b_in(cb),
    .bias_enable_out(bias_en), .bias_from_alt_out(from_alt), .serial_active_out(ser),
    .buck_enable_out(buck), .force_pwm_out(fpwm), .alt_switched_status_out(sw_st),
    .alt_switch_irq_out(sw_irq), .bus_address_out(addr), .setting_a_out(set_a),
    .setting_b_out(set_b), .dual_phase_out(dual), .power_good_a_oe_out(pa_oe),
    .power_good_a_o_out(pa_o), .power_good_b_oe_out(pb_oe), .power_good_b_o_out(pb_o),
    .interrupt_out_n_oe_out(irq_oe), .interrupt_out_n_o_out(irq_o), .seq_state_out(st));
  always #50 clk_in = ~clk_in;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wait_st(input logic [3:0] s);
    int i;
    i = 0;
    while (st !== s && i < 100) begin
      tick(1);
      i++;
    end
  endtask
  task automatic iface_wake();
    if_cmd <= 1'b1;
    wait_st(4'h8);
    tick(2);
    check({bias_en, ser, buck}, 4'hc);
    check(set_a, sa);
    check(set_b, sb);
    cfg_wr <= 1'b1;
    tick(1);
    cfg_wr <= 1'b0;
    tick(2);
    check(set_a, ca);
    check({pa_oe, pa_o, pb_o, irq_o}, 4'h0);
    pok <= 2'h2;
    tick(1);
    check(pa_oe, 1'b1);
    pok <= 2'h3;
    sw_en <= 2'h1;
    tick(3);
    check(buck, 2'h1);
    alt_hi <= 1'b1;
    tick(8);
    check({from_alt, sw_st, sw_irq, irq_oe}, 4'hf);
    dis <= 1'b1;
    tick(8);
    check(from_alt, 1'b0);
    irq_clr <= 1'b1;
    tick(1);
    irq_clr <= 1'b0;
    tick(2);
    check(sw_irq, 1'b0);
    sys_ok <= 1'b0;
    tick(8);
    check(ser, 1'b0);
    sys_ok <= 1'b1;
  endtask
  task automatic pin_wake();
    int n;
    if_cmd <= 1'b0;
    sw_en <= 2'h0;
    dis <= 1'b0;
    tick(10);
    check({st, set_a}, 12'h100);
    sb <= 8'h32;
    pin_cmd <= 2'h3;
    wait_st(4'h2);
    check(from_alt, 1'b0);
    wait_st(4'h4);
    n = 0;
    while (buck[0] !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check(n >= WAKE_DELAY_CYCLES && n <= WAKE_DELAY_CYCLES + 3, 1'b1);
    check({dual, buck[1], pb_oe}, 3'h5);
    fa_n <= 1'b0;
    tick(8);
    check(fpwm, 2'h1);
  endtask
  task automatic addr_straps();
    logic [1:0] code [3] = '{2'h1, 2'h2, 2'h3};
    logic [1:0] exp [3] = '{ADDR_LOW, ADDR_HIGH, ADDR_OPEN};
    // The address strap is only read during wake, so each code needs a fresh wake.
    for (int i = 0; i < 3; i++) begin
      pin_cmd <= 2'h0;
      if_cmd <= 1'b0;
      {a_hi, a_lo} <= code[i];
      wait_st(4'h1);
      if_cmd <= 1'b1;
      wait_st(4'h8);
      check(addr, exp[i]);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    fails++;
    conclude();
  end
  initial begin
    tick(3);
    rst_n_in <= 1'b1;
    tick(6);
    check({st, addr, bias_en, ser}, 8'h14);
    iface_wake();
    pin_wake();
    addr_straps();
    conclude();
  end
endmodule
`default_nettype wire
